// File: core/lmd_pkg.sv
// constants for the led illumination drive control block
package lmd_pkg;
  // apb register byte offsets
  localparam logic [7:0] LMD_OFS_CTRL = 8'h00;
  localparam logic [7:0] LMD_OFS_STATUS = 8'h04;
  localparam logic [7:0] LMD_OFS_RED = 8'h08;
  localparam logic [7:0] LMD_OFS_GREEN = 8'h0C;
  localparam logic [7:0] LMD_OFS_BLUE = 8'h10;
  localparam logic [7:0] LMD_OFS_PULSE = 8'h14;
  localparam logic [7:0] LMD_OFS_SAMPLE = 8'h18;
  // control register fields
  localparam int LMD_CTRL_EN_BIT = 0;
  localparam int LMD_CTRL_MODE_BIT = 1;
  localparam logic [1:0] LMD_CTRL_RESET = 2'h0;
  // per-color register fields
  localparam int LMD_FB_LSB = 0;
  localparam int LMD_FB_W = 12;
  localparam int LMD_PEAK_CURRENT_LIMIT_DAC_LSB = 12;
  localparam int LMD_PEAK_CURRENT_LIMIT_DAC_W = 10;
  localparam int LMD_GAIN_LSB = 22;
  localparam int LMD_TRIM_LSB = 26;
  localparam int LMD_GT_W = 4;
  localparam int LMD_COLOR_W = 30;
  localparam logic [29:0] LMD_COLOR_RESET = 30'h0000_0000;
  // gain steps 0..13, trim codes 0..8 meaning 1.0 down to 0.2
  localparam logic [3:0] LMD_GAIN_MAX = 4'hD;
  localparam logic [3:0] LMD_TRIM_MAX = 4'h8;
  // pulse register fields
  localparam int LMD_PCNT_LSB = 0;
  localparam int LMD_PCNT_W = 6;
  localparam int LMD_POFF_LSB = 8;
  localparam int LMD_POFF_W = 8;
  localparam logic [15:0] LMD_PULSE_RESET = 16'h0401;
  // sample timer delay
  localparam int LMD_SDLY_W = 16;
  localparam logic [15:0] LMD_SDLY_RESET = 16'h0010;
  // color select code width and led channels
  localparam int LMD_CODE_W = 4;
  localparam int LMD_LED_N = 3;
  // discontinuous pulse mode states
  typedef enum logic [1:0] {
    LMD_DM_IDLE,
    LMD_DM_ON,
    LMD_DM_OFF,
    LMD_DM_DONE
  } lmd_dm_state_t;
endpackage

// File: core/lmd_sync3.sv
// three flop input synchroniser with agreement filter
`timescale 1ns/100ps
module lmd_sync3 #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // per bit: first flop feeds only the second one
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
          s3_reg[g] <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          s1_reg[g] <= i_async[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          // a change counts only once the later stages agree
          if (s2_reg[g] == s3_reg[g]) begin
            o_sync[g] <= s3_reg[g];
          end
        end
      end
    end
  endgenerate
endmodule

// File: core/lmd_sample_timer.sv
// hardware sample timer firing one adc conversion per slice
`timescale 1ns/100ps
module lmd_sample_timer
  import lmd_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [LMD_SDLY_W-1:0] i_delay,
  output logic o_fire
);
  logic [LMD_SDLY_W-1:0] cnt_reg;
  logic run_reg;

  // restart on every slice start, fire once when delay is reached
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      o_fire <= 1'b0;
    end else begin
      o_fire <= 1'b0;
      if (i_start) begin
        cnt_reg <= '0;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg == i_delay) begin
          run_reg <= 1'b0;
          o_fire <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule

// File: core/lmd_drive_ctrl.sv
// led illumination drive control with apb register slave
//
// Behaviour
// - continuous light mode and discontinuous pulse mode both supported
// - continuous mode: gate on while light is below dac reference
// - continuous mode: gate off promptly once light exceeds reference
// - hysteretic on/off cycling repeats while led circuit stays enabled
// - pulse mode: comparator crossing ends each light pulse
// - amp gain selectable in 14 steps plus per-color trim 1.0 to 0.2
// - 10-bit setting drives the peak current limit dac
// - drive off-time override and separate enable for buck controller
// - per-color parameters, active color's values muxed to analog
// - two shunt fet controls for blanking and pulse mode
// - sample timer triggers adc conversions at configurable times
// - output cap select low in continuous, high in pulse mode
// - continuous mode: short shunt held until peak current reached, then led enabled; pulse mode holds it for the whole charge
`timescale 1ns/100ps
module lmd_drive_ctrl
  import lmd_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // display controller requests
  input wire logic [LMD_CODE_W-1:0] i_color_select_code,
  input wire logic i_display_drive_request,
  input wire logic i_short_shunt_request,
  input wire logic i_dissipative_shunt_request,
  // analog feedback
  input wire logic i_light_below_ref,
  input wire logic i_peak_current_reached,
  // buck controller and fet drivers
  output logic o_buck_drive_gate,
  output logic o_buck_enable,
  output logic o_off_time_override,
  output logic [LMD_LED_N-1:0] o_led_fet,
  output logic o_short_shunt,
  output logic o_dissipative_shunt,
  output logic o_output_cap_select,
  // analog settings of the active color and the adc convert strobe
  output logic [LMD_FB_W-1:0] o_feedback_dac,
  output logic [LMD_PEAK_CURRENT_LIMIT_DAC_W-1:0] o_peak_current_limit_dac,
  output logic [LMD_GT_W-1:0] o_primary_photo_amp_gain,
  output logic [LMD_GT_W-1:0] o_primary_photo_amp_trim,
  output logic o_adc_convert
);
  logic [1:0] ctrl_reg;
  logic [LMD_COLOR_W-1:0] color_reg [LMD_LED_N];
  logic [15:0] pulse_reg;
  logic [LMD_SDLY_W-1:0] sdly_reg;
  logic [7:0] sync_in;
  logic [7:0] sync_q;
  logic [LMD_CODE_W-1:0] code;
  logic drv_req;
  logic short_req;
  logic diss_req;
  logic comp_below;
  logic peak_hit;
  logic drv_req_reg;
  logic peak_done_reg;
  logic slice_start;
  logic enable;
  logic dm_mode;
  logic active;
  logic [LMD_COLOR_W-1:0] sel_next;
  logic gate_next;
  lmd_dm_state_t dm_state_reg;
  logic [LMD_PCNT_W-1:0] pcnt_reg;
  logic [LMD_POFF_W-1:0] poff_reg;
  logic apb_acc;
  logic adc_fire;
  logic [LMD_GT_W-1:0] gain_raw;
  logic [LMD_GT_W-1:0] trim_raw;

  // all display controller and analog inputs cross in from outside
  assign sync_in = {i_color_select_code, i_display_drive_request,
    i_short_shunt_request, i_dissipative_shunt_request,
    i_light_below_ref};
  lmd_sync3 #(.W(8)) u_sync (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_async(sync_in),
    .o_sync(sync_q)
  );
  // second input group, kept separate so peak detect has its own filter
  lmd_sync3 #(.W(1)) u_sync_peak (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_async(i_peak_current_reached),
    .o_sync(peak_hit)
  );
  assign code = sync_q[7:4];
  assign drv_req = sync_q[3];
  assign short_req = sync_q[2];
  assign diss_req = sync_q[1];
  assign comp_below = sync_q[0];
  assign enable = ctrl_reg[LMD_CTRL_EN_BIT];
  assign dm_mode = ctrl_reg[LMD_CTRL_MODE_BIT];
  // no led selected means nothing to light
  assign active = enable && drv_req && (code[LMD_LED_N-1:0] != '0);

  // apb: zero wait state, every access done in its access phase
  assign apb_acc = i_psel && i_penable;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_reg <= LMD_CTRL_RESET;
      color_reg <= '{default: LMD_COLOR_RESET};
      pulse_reg <= LMD_PULSE_RESET;
      sdly_reg <= LMD_SDLY_RESET;
    end else if (apb_acc && i_pwrite) begin
      unique case (i_paddr)
        LMD_OFS_CTRL: ctrl_reg <= i_pwdata[1:0];
        LMD_OFS_RED: color_reg[0] <= i_pwdata[LMD_COLOR_W-1:0];
        LMD_OFS_GREEN: color_reg[1] <= i_pwdata[LMD_COLOR_W-1:0];
        LMD_OFS_BLUE: color_reg[2] <= i_pwdata[LMD_COLOR_W-1:0];
        LMD_OFS_PULSE: pulse_reg <= i_pwdata[15:0];
        LMD_OFS_SAMPLE: sdly_reg <= i_pwdata[LMD_SDLY_W-1:0];
        default: ;
      endcase
    end
  end

  // read data and error; unmapped addresses answer with pslverr
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      if (i_psel && !i_penable) begin
        unique case (i_paddr)
          LMD_OFS_CTRL: o_prdata <= {30'h0000_0000, ctrl_reg};
          LMD_OFS_STATUS: o_prdata <= {24'h00_0000, code,
            (dm_state_reg != LMD_DM_IDLE), o_buck_drive_gate,
            comp_below, peak_done_reg};
          LMD_OFS_RED: o_prdata <= {2'h0, color_reg[0]};
          LMD_OFS_GREEN: o_prdata <= {2'h0, color_reg[1]};
          LMD_OFS_BLUE: o_prdata <= {2'h0, color_reg[2]};
          LMD_OFS_PULSE: o_prdata <= {16'h0000, pulse_reg};
          LMD_OFS_SAMPLE: o_prdata <= {16'h0000, sdly_reg};
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  // select the active color's parameters straight from the synced code
  always_comb begin
    sel_next = LMD_COLOR_RESET;
    for (int c = 0; c < LMD_LED_N; c++) begin
      if (code[c]) begin
        sel_next = color_reg[c];
      end
    end
  end
  assign gain_raw = sel_next[LMD_GAIN_LSB +: LMD_GT_W];
  assign trim_raw = sel_next[LMD_TRIM_LSB +: LMD_GT_W];

  // analog settings registered in the same cycle as the led fets
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_feedback_dac <= '0;
      o_peak_current_limit_dac <= '0;
      o_primary_photo_amp_gain <= '0;
      o_primary_photo_amp_trim <= '0;
    end else begin
      o_feedback_dac <= sel_next[LMD_FB_LSB +: LMD_FB_W];
      o_peak_current_limit_dac <=
        sel_next[LMD_PEAK_CURRENT_LIMIT_DAC_LSB +: LMD_PEAK_CURRENT_LIMIT_DAC_W];
      // out-of-range codes clamp rather than wrap the gain
      o_primary_photo_amp_gain <= (gain_raw > LMD_GAIN_MAX) ?
        LMD_GAIN_MAX : gain_raw;
      o_primary_photo_amp_trim <= (trim_raw > LMD_TRIM_MAX) ?
        LMD_TRIM_MAX : trim_raw;
    end
  end

  // peak current latch for the charging phase; set wins over clear
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      peak_done_reg <= 1'b0;
    end else if (short_req && peak_hit) begin
      peak_done_reg <= 1'b1;
    end else if (!short_req) begin
      peak_done_reg <= 1'b0;
    end
  end

  // slice start edge for the sample timer only
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drv_req_reg <= 1'b0;
    end else begin
      drv_req_reg <= drv_req;
    end
  end
  assign slice_start = drv_req && !drv_req_reg;

  // pulse mode sequencer: pulses end on the comparator crossing
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dm_state_reg <= LMD_DM_IDLE;
      pcnt_reg <= '0;
      poff_reg <= '0;
    end else if (!dm_mode || !active) begin
      dm_state_reg <= LMD_DM_IDLE;
    end else begin
      unique case (dm_state_reg)
        LMD_DM_IDLE: begin
          pcnt_reg <= pulse_reg[LMD_PCNT_LSB +: LMD_PCNT_W];
          dm_state_reg <= LMD_DM_ON;
        end
        LMD_DM_ON: begin
          if (!comp_below) begin
            dm_state_reg <= LMD_DM_OFF;
            pcnt_reg <= pcnt_reg - 1'b1;
            poff_reg <= pulse_reg[LMD_POFF_LSB +: LMD_POFF_W];
          end
        end
        LMD_DM_OFF: begin
          if (poff_reg != '0) begin
            poff_reg <= poff_reg - 1'b1;
          end else if (pcnt_reg != '0) begin
            dm_state_reg <= LMD_DM_ON;
          end else begin
            dm_state_reg <= LMD_DM_DONE;
          end
        end
        LMD_DM_DONE: ;
      endcase
    end
  end

  // gate decision; dissipative phase keeps the buck off
  always_comb begin
    gate_next = 1'b0;
    if (!active || diss_req) begin
      gate_next = 1'b0;
    end else if (dm_mode) begin
      gate_next = (dm_state_reg == LMD_DM_ON) && comp_below;
    end else if (short_req && !peak_done_reg) begin
      gate_next = 1'b1;
    end else begin
      // plain follower: cycles on/off as long as enabled
      gate_next = comp_below;
    end
  end

  // buck, shunt and led fet outputs, all registered
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_buck_drive_gate <= 1'b0;
      o_buck_enable <= 1'b0;
      o_off_time_override <= 1'b0;
      o_short_shunt <= 1'b0;
      o_dissipative_shunt <= 1'b0;
      o_led_fet <= '0;
      o_output_cap_select <= 1'b0;
    end else begin
      o_buck_drive_gate <= gate_next;
      o_buck_enable <= enable;
      // hold the external off timer between discrete pulses
      o_off_time_override <= dm_mode && active &&
        (dm_state_reg == LMD_DM_OFF);
      o_short_shunt <= enable && short_req &&
        (dm_mode || !peak_done_reg);
      o_dissipative_shunt <= enable && diss_req;
      // led lit once the shunts have let go, or in pulse mode with the short shunt still on
      o_led_fet <= (enable && drv_req && !diss_req &&
        (!short_req || peak_done_reg || dm_mode)) ?
        code[LMD_LED_N-1:0] : '0;
      o_output_cap_select <= dm_mode;
    end
  end

  // adc conversions timed from each slice start
  lmd_sample_timer u_timer (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_start(slice_start && enable),
    .i_delay(sdly_reg),
    .o_fire(adc_fire)
  );
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_adc_convert <= 1'b0;
    end else begin
      o_adc_convert <= adc_fire;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_pulse_peak;
    dm_mode && active && !diss_req && dm_state_reg == LMD_DM_ON &&
      !comp_below;
  endsequence
  sequence s_pulse_gap;
    !o_buck_drive_gate ##1 o_off_time_override;
  endsequence

  chk_gate_idle_off: assert property (
    !active |=> !o_buck_drive_gate)
    else $error("gate on while led inactive");
  chk_cm_gate_on: assert property (
    !dm_mode && active && !diss_req && !short_req && comp_below
    |=> o_buck_drive_gate)
    else $error("gate not on with light below reference");
  chk_cm_gate_off: assert property (
    !dm_mode && active && !short_req && !comp_below
    |=> !o_buck_drive_gate)
    else $error("gate not off above reference");
  // a slice that ends right on the peak idles the sequencer, so no gap
  chk_dm_pulse_end: assert property (
    s_pulse_peak ##1 (dm_mode && active) |-> s_pulse_gap)
    else $error("pulse not ended at peak");
  chk_cap_mode: assert property (
    ##1 o_output_cap_select == $past(dm_mode))
    else $error("cap select does not follow mode");
  chk_shunt_hold: assert property (
    enable && !dm_mode && short_req && !peak_done_reg
    |=> o_short_shunt && o_led_fet == '0)
    else $error("short shunt released before peak");
  chk_param_follow: assert property (
    $changed(code) && code == 4'h1 |=>
    o_feedback_dac == $past(color_reg[0][LMD_FB_W-1:0]))
    else $error("dac not switched with color code");
  chk_peak_current_limit_dac_follow: assert property (
    code == 4'h4 |=>
    o_peak_current_limit_dac == $past(color_reg[2][21:12]))
    else $error("current limit not from active color");
  chk_gain_range: assert property (
    o_primary_photo_amp_gain <= LMD_GAIN_MAX &&
    o_primary_photo_amp_trim <= LMD_TRIM_MAX)
    else $error("gain or trim out of range");
  chk_adc_one_shot: assert property (
    o_adc_convert |=> !o_adc_convert)
    else $error("adc convert longer than one cycle");
endmodule

// File: tb/lmd_display_model.sv
// display controller model issuing one color slice per go request
`timescale 1ns/100ps
module lmd_display_model
  import lmd_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_go,
  input wire logic [LMD_CODE_W-1:0] i_code,
  input wire logic [7:0] i_len,
  output logic [LMD_CODE_W-1:0] o_color_select_code,
  output logic o_display_drive_request,
  output logic o_short_shunt_request,
  output logic o_dissipative_shunt_request
);
  logic [8:0] step_reg;
  logic [8:0] step_next;
  // timeline: 8 dissipate, 32 charge, then i_len lit cycles
  assign step_next = (step_reg == 9'd40 + {1'b0, i_len}) ? 9'd0 :
                     step_reg + 9'd1;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      step_reg <= 9'd0;
    end else if (step_reg != 9'd0 || i_go) begin
      step_reg <= step_next;
    end
  end
  // requests decoded from the timeline; lengths set attenuation
  always_comb begin
    o_dissipative_shunt_request = step_reg >= 9'd1 &&
      step_reg <= 9'd8;
    o_short_shunt_request = step_reg >= 9'd9 && step_reg <= 9'd40;
    o_display_drive_request = step_reg >= 9'd9;
    // code only during charge and lit, leds dark while dissipating
    o_color_select_code = (step_reg >= 9'd9) ? i_code : '0;
  end
endmodule

// File: tb/led_illumination_drive_control_test.sv
// bench for the led drive control block through apb and a slice model
`timescale 1ns/100ps
module led_illumination_drive_control_test
  import lmd_pkg::*;
;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, go;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] code, mcode, gain, trim;
  logic drv, ssr, dsr, below, peak, gate, ben, ovr, sh, dsh, cap, adc;
  logic [2:0] led;
  logic [11:0] fbd;
  logic [9:0] peak_current_limit_dac;
  logic [29:0] colv [3];
  int errors = 0;
  int checks = 0;
  int adc_n = 0;
  // reset values of the writable registers, in address order
  logic [7:0] ra [6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [6] = '{0, 0, 0, 0, 32'h0000_0401, 32'h0000_0010};
  lmd_drive_ctrl dut (.i_mclk(mclk), .i_reset_n(reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_color_select_code(code),
    .i_display_drive_request(drv), .i_short_shunt_request(ssr),
    .i_dissipative_shunt_request(dsr), .i_light_below_ref(below),
    .i_peak_current_reached(peak), .o_buck_drive_gate(gate),
    .o_buck_enable(ben), .o_off_time_override(ovr), .o_led_fet(led),
    .o_short_shunt(sh), .o_dissipative_shunt(dsh),
    .o_output_cap_select(cap), .o_feedback_dac(fbd),
    .o_peak_current_limit_dac(peak_current_limit_dac), .o_primary_photo_amp_gain(gain),
    .o_primary_photo_amp_trim(trim), .o_adc_convert(adc));
  lmd_display_model partner (.i_mclk(mclk), .i_reset_n(reset_n),
    .i_go(go), .i_code(mcode), .i_len(8'd60), .o_color_select_code(code),
    .o_display_drive_request(drv), .o_short_shunt_request(ssr),
    .o_dissipative_shunt_request(dsr));
  always #2 mclk = ~mclk;
  // conversion pulses counted for per-slice comparison
  always @(posedge mclk) if (adc === 1'b1) adc_n <= adc_n + 1;
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, idle cycle after so strobes never toggle twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] exp,
                     input logic experr);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      print_verdict();
    end
    if (!w) check(prdata, exp);
    check({31'h0, pslverr}, {31'h0, experr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // bounded wait on a model or design level
  task automatic wait_until(input int which);
    int n;
    bit hit;
    for (n = 0; n < 400; n++) begin
      @(posedge mclk);
      case (which)
        0: hit = dsr === 1'b1;
        1: hit = ssr === 1'b1;
        2: hit = ssr === 1'b0 && drv === 1'b1;
        3: hit = drv === 1'b0;
        4: hit = gate === 1'b1;
        default: hit = ovr === 1'b1;
      endcase
      if (hit) return;
    end
    errors++;
    print_verdict();
  endtask
  task automatic start(input int c);
    go <= 1'b1;
    mcode <= 4'(1 << c);
    @(posedge mclk);
    go <= 1'b0;
  endtask
  // one continuous mode slice with checks of every output but the off-time override
  task automatic cm_slice(input int c);
    logic [29:0] v;
    logic [3:0] g_exp;
    logic [3:0] t_exp;
    int n0;
    v = colv[c];
    n0 = adc_n;
    // analog codes clamp at the top step, they never wrap
    g_exp = (v[25:22] > LMD_GAIN_MAX) ? LMD_GAIN_MAX : v[25:22];
    t_exp = (v[29:26] > LMD_TRIM_MAX) ? LMD_TRIM_MAX : v[29:26];
    below <= 1'b1;
    start(c);
    wait_until(0);
    repeat (7) @(posedge mclk);
    check({31'h0, dsh}, 1);
    check({31'h0, gate}, 0);
    wait_until(1);
    repeat (7) @(posedge mclk);
    check({sh, led, gate}, 5'b1_000_1);
    check({20'h0, fbd}, {20'h0, v[11:0]});
    check({22'h0, peak_current_limit_dac}, {22'h0, v[21:12]});
    check({28'h0, gain}, {28'h0, g_exp});
    check({28'h0, trim}, {28'h0, t_exp});
    check({cap, ben}, 2'b01);
    peak <= 1'b1;
    repeat (7) @(posedge mclk);
    check({sh, led}, {1'b0, 3'(1 << c)});
    wait_until(2);
    repeat (3) begin
      below <= 1'b0;
      repeat (7) @(posedge mclk);
      check({31'h0, gate}, 0);
      below <= 1'b1;
      repeat (7) @(posedge mclk);
      check({31'h0, gate}, 1);
    end
    wait_until(3);
    repeat (7) @(posedge mclk);
    check({31'h0, gate}, 0);
    check(adc_n - n0, 1);
    peak <= 1'b0;
  endtask
  initial begin
    int n;
    mclk = 0;
    reset_n = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    go = 0;
    mcode = 0;
    below = 0;
    peak = 0;
    colv = '{{4'h2, 4'h3, 10'h155, 12'hABC},
             {4'h9, 4'hF, 10'h2AA, 12'h123},
             {4'h8, 4'hD, 10'h3FF, 12'hFFF}};
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (n = 0; n < 6; n++) apb(0, ra[n], 0, rv[n], 0);
    apb(0, 8'h1C, 0, 0, 1);
    apb(1, 8'h04, 32'hFFFF_FFFF, 0, 0);
    for (n = 0; n < 3; n++) begin
      apb(1, 8'h08 + 8'(4 * n), {2'b11, colv[n]}, 0, 0);
      apb(0, 8'h08 + 8'(4 * n), 0, {2'b00, colv[n]}, 0);
    end
    apb(1, 8'h18, 32'h0000_0005, 0, 0);
    apb(1, 8'h00, 32'h0000_0001, 0, 0);
    apb(0, 8'h00, 0, 32'h0000_0001, 0);
    for (n = 0; n < 3; n++) cm_slice(n);
    // pulse mode: two pulses, four off cycles
    apb(1, 8'h14, 32'h0000_0302, 0, 0);
    apb(1, 8'h00, 32'h0000_0003, 0, 0);
    repeat (6) @(posedge mclk);
    check({31'h0, cap}, 1);
    below <= 1'b1;
    peak <= 1'b1;
    start(0);
    wait_until(4);
    // pulse mode: short shunt ignores the peak latch, led already lit
    check({sh, led}, 4'b1_001);
    below <= 1'b0;
    wait_until(5);
    check({31'h0, gate}, 0);
    n = 1;
    while (n < 50) begin
      @(posedge mclk);
      if (ovr !== 1'b1) break;
      n++;
    end
    check(n, 4);
    below <= 1'b1;
    wait_until(3);
    peak <= 1'b0;
    // disabled: all drive outputs held off
    apb(1, 8'h00, 32'h0000_0000, 0, 0);
    start(1);
    wait_until(1);
    repeat (7) @(posedge mclk);
    check({gate, sh, ben}, 3'b000);
    // status: green code, comparator high, gate and sequencer idle
    apb(0, 8'h04, 0, 32'h0000_0022, 0);
    wait_until(3);
    print_verdict();
  end
endmodule
